/* File: pin_edge_detect.sv */
// Pin synchroniser with registered level and edge pulses.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Pin and results
    input wire logic pin_async,
    output logic level,
    output logic rise,
    output logic fall
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;

    // ==========================================================
    // Two-stage synchroniser; only the second stage is looked at.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else if (ce) begin
            sync1_ff <= pin_async;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign level = sync2_ff;
    assign rise = ce & sync2_ff & ~prev_ff;
    assign fall = ce & ~sync2_ff & prev_ff;
endmodule
`default_nettype wire

/* File: pin_partner.sv */
// Far-side model of the port pins and the open-drain reset line.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    // Levels that outside circuits put on undriven pins
    input wire logic [7:0] ext_lvl,
    // Pin drive from the timer
    input wire logic [7:0] pa_o,
    input wire logic [7:0] pa_oe_n,
    output logic [7:0] pa_i,
    // Reset wire
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe_n,
    output logic rst_pin_i
);
    // ==========================================================
    // Pin levels
    // A driven pin reads back its own drive, so a port read sees what leaves the chip.
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            pa_i[k] = pa_oe_n[k] ? ext_lvl[k] : pa_o[k];
        end
    end
    // A pull-up holds the reset wire high whenever nobody pulls it low.
    assign rst_pin_i = rst_pin_oe_n ? 1'b1 : rst_pin_o;
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the timer capture and compare system.
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module tb;
    // ==========================================================
    // Signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] ext_lvl = 8'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, rst_pin_i, rst_pin_o, rst_pin_oe_n;
    logic [7:0] pa_i, pa_o, pa_oe_n;
    logic [11:0] irq_req;
    logic [15:0] c1, d;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int p, n, w;
    always #25 pclk = ~pclk;
    timer_capture_compare_system #(.RTI_SHIFT(3), .WD_SHIFT(4)) timer_capture_compare_system_i (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_i(pa_i), .pa_o(pa_o), .pa_oe_n(pa_oe_n), .irq_req(irq_req),
        .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n));
    pin_partner pin_partner_i (.ext_lvl(ext_lvl), .pa_o(pa_o), .pa_oe_n(pa_oe_n), .pa_i(pa_i),
        .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n), .rst_pin_i(rst_pin_i));
    // ==========================================================
    // Tasks
    task automatic tally_and_finish();
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    // Holds the request until pready is seen; the setup edge is where read data is caught.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            k++;
            @(posedge pclk);
        end
        if (k >= 50) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // ==========================================================
    // Timeout and main sequence
    always @(posedge pclk) begin
        cycles++;
        if (cycles >= 90000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(68380));
        idle(12);
        presetn <= 1'b1;
        idle(1);
        apb(0, `A_CTRL, 0);
        chk_reg(rd, 32'h0);
        apb(0, `A_STAT, 0);
        chk_reg(rd, 32'h2);
        apb(0, 8'hfc, 0);
        chk_pin(err, 1'b1);
        for (int code = 0; code < 4; code++) begin
            p = $urandom % 3;
            apb(1, `A_EDGE, 32'(code) << (2 * p));
            apb(1, `A_FLAGS, 32'h0fff);
            apb(0, `A_COUNT, 0);
            c1 = rd[15:0];
            ext_lvl[p] <= 1'b1;
            idle(8);
            apb(0, `A_PORT, 0);
            chk_pin(rd[p], 1'b1);
            apb(0, `A_FLAGS, 0);
            chk_pin(rd[p], code[0]);
            apb(0, {`CAP_PG, 4'(4 * p)}, 0);
            d = rd[15:0] - c1;
            if (code[0]) chk_pin(d >= 16'h3 && d <= 16'ha, 1'b1);
            apb(1, `A_FLAGS, 32'h0fff);
            ext_lvl[p] <= 1'b0;
            idle(8);
            apb(0, `A_FLAGS, 0);
            chk_pin(rd[p], code[1]);
        end
        // Pin 3 as the fourth capture channel, rising edges.
        apb(1, `A_CTRL, 32'h80);
        apb(1, `A_EDGE, 32'h40);
        apb(1, `A_FLAGS, 32'h0fff);
        ext_lvl[3] <= 1'b1;
        idle(8);
        apb(0, `A_FLAGS, 0);
        chk_pin(rd[`I_IC4], 1'b1);
        for (int ps = 0; ps < 4; ps++) begin
            apb(1, `A_CTRL, 32'(ps));
            apb(0, `A_COUNT, 0);
            c1 = rd[15:0];
            apb(1, `A_COUNT, $urandom);
            idle(42);
            apb(0, `A_COUNT, 0);
            chk_reg(32'(rd[15:0] - c1), 32'(48 >> (ps == 0 ? 0 : ps + 1)));
        end
        // Event mode on rising edges, then gated mode while the pin is high.
        apb(1, `A_CTRL, 32'h50);
        apb(1, `A_PACNT, 0);
        n = 3 + $urandom % 6;
        for (int i = 0; i < n; i++) begin
            ext_lvl[7] <= 1'b1;
            idle(4);
            ext_lvl[7] <= 1'b0;
            idle(4);
        end
        apb(0, `A_PACNT, 0);
        chk_reg(rd, 32'(n));
        apb(1, `A_CTRL, 32'h70);
        apb(1, `A_PACNT, 0);
        ext_lvl[7] <= 1'b1;
        idle(640);
        ext_lvl[7] <= 1'b0;
        idle(4);
        apb(0, `A_PACNT, 0);
        chk_pin(rd >= 9 && rd <= 11, 1'b1);
        apb(1, `A_CTRL, 0);
        apb(1, `A_DDR, 32'h80);
        apb(1, `A_PORT, 32'h80);
        idle(3);
        chk_pin(pa_o[7] & ~pa_oe_n[7], 1'b1);
        apb(0, `A_COUNT, 0);
        c1 = rd[15:0];
        apb(1, `A_OC1, 32'h1010);
        apb(1, {`CMP_PG, 4'h0}, 32'(c1 + 16'h28));
        chk_pin(pa_o[7], 1'b0);
        idle(50);
        apb(1, `A_PORT, 32'h00);
        idle(3);
        chk_pin(pa_o[7], 1'b1);
        apb(1, `A_IE, 32'h100);
        w = 0;
        while (irq_req[8] !== 1'b1 && w < 70000) begin
            w++;
            idle(1);
        end
        if (w >= 70000) num_errors++;
        apb(0, `A_COUNT, 0);
        chk_pin(rd[15:0] < 16'h0010, 1'b1);
        apb(1, `A_IE, 0);
        idle(2);
        chk_pin(irq_req[8], 1'b0);
        apb(0, `A_FLAGS, 0);
        chk_pin(rd[`I_TOF], 1'b1);
        // Periodic flag spacing at the fastest and slowest rate: 2**(3+r) cycles here.
        apb(1, `A_IE, 32'h200);
        for (int r = 0; r < 4; r += 3) begin
            apb(1, `A_CTRL, 32'(r) << 2);
            repeat (2) begin
                apb(1, `A_FLAGS, 32'h0fff);
                w = 0;
                while (irq_req[`I_RTI] !== 1'b1 && w < 300) begin
                    w++;
                    idle(1);
                end
            end
            chk_pin(w + 5 >= (8 << r) && w < (8 << r), 1'b1);
        end
        apb(1, `A_CTRL, 32'h100);
        for (int i = 0; i < 4; i++) begin
            apb(1, `A_WDOG, 32'h5a);
            idle(60);
            chk_pin(rst_pin_oe_n, 1'b1);
        end
        apb(1, `A_WDOG, 32'h5a);
        w = 0;
        while (rst_pin_oe_n !== 1'b0 && w < 300) begin
            w++;
            idle(1);
        end
        chk_pin(w >= 100 && w <= 140, 1'b1);
        chk_pin(rst_pin_i, 1'b0);
        apb(0, `A_STAT, 0);
        chk_pin(rd[0], 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: timer_capture_compare_system.sv */
// Timer system: prescaled counter, capture, compare, accumulator, periodic and watchdog.
//
// Function
// - Counter prescaler divides the bus clock by 1, 4, 8 or 16.
// - Select codes 0,1,2,3 give one count per E/1, E/4, E/8, E/16.
// - 16-bit counter starts at zero after reset, counts up on each tick.
// - At maximum it wraps to zero, sets overflow flag, keeps counting.
// - Software cannot clear, load or stop the counter.
// - Three capture, four compare and one capture-or-compare channel.
// - Each capture and compare channel has its own 16-bit register.
// - Every timer event has its own enable and own request line.
// - Event mode: accumulator counts each selected edge on its input.
// - Gated mode: accumulator counts internal clock while input at level.
// - Periodic interrupt at one of four rates from the divider chain.
// - Watchdog counter clocked by bus clock divided by two to fifteen.
// - Unserviced watchdog times out and pulls the reset pin low.
// - Port read returns current capture pin levels at any time.
// - Each capture pin has edge detection with its own edge choice.
// - Port writes do not drive pins owned by a compare channel.
// - First compare channel may drive any mix of five upper pins.
// - Top pin serves as I/O, accumulator input or first compare output.
// - Edge field: 0 off, 1 rising, 2 falling, 3 either edge.
// - Capture latches a stable count, even at the increment instant.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module timer_capture_compare_system #(
    parameter int RTI_SHIFT = `RTI_SH,
    parameter int WD_SHIFT = `WD_SH
) (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins
    input wire logic [7:0] pa_i,
    output logic [7:0] pa_o,
    output logic [7:0] pa_oe_n,
    // Timer event requests
    output logic [`NIRQ-1:0] irq_req,
    // Open-drain reset pin
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_n
);
    logic [`DIV_W-1:0] div_ff;
    timer_pkg::count_t tcnt_ff;
    logic cnt_step_ff;
    logic [`C_W-1:0] ctrl_ff;
    logic [7:0] edge_ff;
    logic [`NIRQ-1:0] ie_ff;
    logic [`NIRQ-1:0] flags_ff;
    logic [`NIRQ-1:0] flag_set;
    logic [`NIRQ-1:0] flag_clr;
    logic [7:0] port_ff;
    logic [7:0] ddr_ff;
    logic [7:0] pin_out_ff;
    logic [7:0] pin_drv_ff;
    logic [7:3] oc_lvl_ff;
    logic [`O1_W-1:0] oc1_ff;
    timer_pkg::count_t cap_ff [4];
    timer_pkg::count_t cmp_ff [4];
    logic [7:0] pacnt_ff;
    logic [2:0] wd_cnt_ff;
    logic [7:0] wd_hold_ff;
    logic wd_fired_ff;
    timer_pkg::wd_state_t wd_state_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_val;
    logic addr_ok;
    logic [7:0] lvl;
    logic [7:0] rise;
    logic [7:0] fall;
    logic rst_lvl;
    logic ps_tick;
    logic rti_tick;
    logic wd_tick;
    logic pa_tick;
    logic wr;
    logic wd_service;
    logic [3:0] cap_hit;
    logic [3:0] cmp_match;
    logic oc5_match;
    logic [7:0] own;
    logic pa_edge;
    logic pa_inc;
    int ps_sh;

    // True once every bit below the tap is set, so a tap of sh ticks every 2**sh cycles.
    function automatic logic tap(input logic [`DIV_W-1:0] d, input int sh);
        logic [`DIV_W-1:0] m;
        m = `DIV_W'((33'h1 << sh) - 33'h1);
        return &(d | ~m);
    endfunction

    // ==========================================================
    // Divider chain and free-running counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= '0;
        end else if (ce) begin
            div_ff <= div_ff + `DIV_W'(1);
        end
    end

    always_comb begin
        case (ctrl_ff[`C_PSC])
            2'h0: ps_sh = 0;
            2'h1: ps_sh = `PS_SH1;
            2'h2: ps_sh = `PS_SH2;
            default: ps_sh = `PS_SH3;
        endcase
    end

    assign ps_tick = ce & tap(div_ff, ps_sh);
    assign rti_tick = ce & tap(div_ff, RTI_SHIFT + int'(ctrl_ff[`C_RTI]));
    assign wd_tick = ce & tap(div_ff, WD_SHIFT);
    assign pa_tick = ce & tap(div_ff, `PA_SH);

    // No bus path reaches the counter; only the prescaler moves it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_ff <= '0;
            cnt_step_ff <= 1'b0;
        end else if (ce) begin
            cnt_step_ff <= ps_tick;
            if (ps_tick) begin
                tcnt_ff <= tcnt_ff + 16'h1;
            end
        end
    end

    // ==========================================================
    // APB slave: zero wait states while enabled; ce low stalls the bus.
    assign wr = psel & penable & pwrite & ce;
    assign pready = ce;
    assign prdata = prdata_ff;
    assign pslverr = psel & penable & ~addr_ok;

    always_comb begin
        rd_val = 32'h0;
        addr_ok = 1'b1;
        case (paddr)
            `A_CTRL: rd_val = 32'(ctrl_ff);
            `A_COUNT: rd_val = 32'(tcnt_ff);
            `A_EDGE: rd_val = 32'(edge_ff);
            `A_IE: rd_val = 32'(ie_ff);
            `A_FLAGS: rd_val = 32'(flags_ff);
            `A_PORT: rd_val = 32'(lvl);
            `A_DDR: rd_val = 32'(ddr_ff);
            `A_OC1: rd_val = 32'(oc1_ff);
            `A_WDOG: rd_val = 32'(wd_cnt_ff);
            `A_PACNT: rd_val = 32'(pacnt_ff);
            `A_STAT: rd_val = 32'({rst_lvl, wd_fired_ff});
            default: begin
                if (paddr[7:4] == `CAP_PG && paddr[1:0] == 2'h0) begin
                    rd_val = 32'(cap_ff[paddr[3:2]]);
                end else if (paddr[7:4] == `CMP_PG && paddr[1:0] == 2'h0) begin
                    rd_val = 32'(cmp_ff[paddr[3:2]]);
                end else begin
                    addr_ok = 1'b0;
                end
            end
        endcase
    end

    // Read data is caught in the setup cycle so it stands through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata_ff <= rd_val;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '0;
            edge_ff <= 8'h0;
            ie_ff <= '0;
            port_ff <= 8'h0;
            ddr_ff <= 8'h0;
            oc1_ff <= '0;
        end else if (wr) begin
            case (paddr)
                `A_CTRL: ctrl_ff <= pwdata[`C_W-1:0];
                `A_EDGE: edge_ff <= pwdata[7:0];
                `A_IE: ie_ff <= pwdata[`NIRQ-1:0];
                `A_PORT: port_ff <= pwdata[7:0];
                `A_DDR: ddr_ff <= pwdata[7:0];
                `A_OC1: oc1_ff <= pwdata[`O1_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Flags: a hardware set in the same cycle as a clear wins.
    assign flag_clr = (wr && paddr == `A_FLAGS) ? pwdata[`NIRQ-1:0] : '0;
    assign flag_set = {pa_edge & ctrl_ff[`C_PA_EN], pa_inc & (pacnt_ff == 8'hff), rti_tick,
                       ps_tick & (tcnt_ff == 16'hffff), cmp_match,
                       cap_hit[3] | oc5_match, cap_hit[2:0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= '0;
        end else if (ce) begin
            flags_ff <= (flags_ff & ~flag_clr) | flag_set;
        end
    end

    assign irq_req = flags_ff & ie_ff;

    // ==========================================================
    // Port pins: synchronise, capture, compare outputs and drivers.
    pin_edge_detect u_rst_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin_async(rst_pin_i),
        .level(rst_lvl),
        .rise(),
        .fall()
    );

    for (genvar i = 0; i < 8; i++) begin : g_pin
        pin_edge_detect u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .pin_async(pa_i[i]),
            .level(lvl[i]),
            .rise(rise[i]),
            .fall(fall[i])
        );
        if (i < 4) begin : g_cap
            logic [1:0] es;
            logic armed;
            assign es = edge_ff[2*i+1:2*i];
            assign armed = (i != 3) || ctrl_ff[`C_IC4];
            assign cap_hit[i] = armed & (((es == `EDG_RISE) & rise[i]) |
                                ((es == `EDG_FALL) & fall[i]) |
                                ((es == `EDG_ANY) & (rise[i] | fall[i])));
            // The capture takes the count held before this edge's increment.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cap_ff[i] <= '0;
                end else if (cap_hit[i]) begin
                    cap_ff[i] <= tcnt_ff;
                end else if (i == 3 && wr && !ctrl_ff[`C_IC4] && paddr == `A_CAP3) begin
                    cap_ff[i] <= pwdata[15:0];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cmp_ff[i] <= '0;
                end else if (wr && paddr[7:4] == `CMP_PG && paddr[3:2] == 2'(i)) begin
                    cmp_ff[i] <= pwdata[15:0];
                end
            end
            assign cmp_match[i] = cnt_step_ff & (tcnt_ff == cmp_ff[i]);
        end
        if (i < 3) begin : g_in
            assign own[i] = 1'b0;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_out_ff[i] <= 1'b0;
                    pin_drv_ff[i] <= 1'b0;
                end else if (ce) begin
                    pin_out_ff[i] <= port_ff[i];
                    pin_drv_ff[i] <= 1'b0;
                end
            end
        end else begin : g_out
            logic chan_match;
            logic m1;
            assign m1 = cmp_match[0] & oc1_ff[i-3];
            if (i == 7) begin : g_top
                assign chan_match = 1'b0;
                assign own[i] = oc1_ff[i-3];
            end else if (i == 3) begin : g_oc5
                assign chan_match = oc5_match;
                assign own[i] = oc1_ff[i-3] | (ctrl_ff[9+i-3] & ~ctrl_ff[`C_IC4]);
            end else begin : g_ocn
                assign chan_match = cmp_match[7-i];
                assign own[i] = oc1_ff[i-3] | ctrl_ff[9+i-3];
            end
            // The first channel overrides a toggle due on the same pin.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    oc_lvl_ff[i] <= 1'b0;
                end else if (ce && m1) begin
                    oc_lvl_ff[i] <= oc1_ff[8+i-3];
                end else if (ce && chan_match && own[i]) begin
                    oc_lvl_ff[i] <= ~oc_lvl_ff[i];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_out_ff[i] <= 1'b0;
                    pin_drv_ff[i] <= 1'b0;
                end else if (ce) begin
                    pin_out_ff[i] <= own[i] ? oc_lvl_ff[i] : port_ff[i];
                    pin_drv_ff[i] <= own[i] | ((i == 3 || i == 7) ? ddr_ff[i] : 1'b1);
                end
            end
        end
    end

    assign oc5_match = cnt_step_ff & ~ctrl_ff[`C_IC4] & (tcnt_ff == cap_ff[3]);
    assign pa_o = pin_out_ff;
    assign pa_oe_n = ~pin_drv_ff;

    // ==========================================================
    // Pulse accumulator on the top pin
    assign pa_edge = ctrl_ff[`C_PA_POL] ? rise[7] : fall[7];
    assign pa_inc = ctrl_ff[`C_PA_EN] & (ctrl_ff[`C_PA_GATE] ?
                    (pa_tick & (lvl[7] == ctrl_ff[`C_PA_POL])) : pa_edge);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pacnt_ff <= 8'h0;
        end else if (wr && paddr == `A_PACNT) begin
            pacnt_ff <= pwdata[7:0];
        end else if (pa_inc) begin
            pacnt_ff <= pacnt_ff + 8'h1;
        end
    end

    // ==========================================================
    // Watchdog: times out after WD_LIMIT+1 ticks without the service key.
    assign wd_service = wr && paddr == `A_WDOG && pwdata[7:0] == `WD_KEY;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_state_ff <= timer_pkg::WD_OFF;
            wd_cnt_ff <= 3'h0;
            wd_hold_ff <= 8'h0;
        end else if (ce) begin
            case (wd_state_ff)
                timer_pkg::WD_OFF: begin
                    wd_cnt_ff <= 3'h0;
                    if (ctrl_ff[`C_WD_EN]) begin
                        wd_state_ff <= timer_pkg::WD_RUN;
                    end
                end
                timer_pkg::WD_RUN: begin
                    if (!ctrl_ff[`C_WD_EN]) begin
                        wd_state_ff <= timer_pkg::WD_OFF;
                    end else if (wd_service) begin
                        wd_cnt_ff <= 3'h0;
                    end else if (wd_tick && wd_cnt_ff == `WD_LIMIT) begin
                        wd_state_ff <= timer_pkg::WD_HOLD;
                        wd_hold_ff <= `WD_HOLD;
                    end else if (wd_tick) begin
                        wd_cnt_ff <= wd_cnt_ff + 3'h1;
                    end
                end
                timer_pkg::WD_HOLD: begin
                    wd_cnt_ff <= 3'h0;
                    if (wd_hold_ff == 8'h0) begin
                        wd_state_ff <= timer_pkg::WD_RUN;
                    end else begin
                        wd_hold_ff <= wd_hold_ff - 8'h1;
                    end
                end
                default: wd_state_ff <= timer_pkg::WD_OFF;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_fired_ff <= 1'b0;
        end else if (ce) begin
            wd_fired_ff <= (wd_fired_ff & ~(wr && paddr == `A_STAT && pwdata[0])) |
                           (wd_state_ff == timer_pkg::WD_HOLD);
        end
    end

    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_n = (wd_state_ff != timer_pkg::WD_HOLD);

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wd_expire;
        wd_state_ff == timer_pkg::WD_RUN && ctrl_ff[`C_WD_EN] && !wd_service &&
        wd_tick && wd_cnt_ff == `WD_LIMIT;
    endsequence
    sequence s_pin_low;
        !rst_pin_oe_n [*8];
    endsequence

    property p_cnt_step;
        ps_tick |=> tcnt_ff == 16'($past(tcnt_ff) + 16'h1);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count did not step");
    property p_cnt_hold;
        !ps_tick |=> $stable(tcnt_ff);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved untimed");
    property p_wrap;
        ps_tick && tcnt_ff == 16'hffff |=> tcnt_ff == 16'h0 && flags_ff[`I_TOF];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap or overflow flag wrong");
    property p_div;
        ps_tick && ctrl_ff[`C_PSC] == 2'h3 |-> div_ff[3:0] == 4'hf;
    endproperty
    a_div: assert property (p_div) else $error("prescale tick off rate");
    property p_capture;
        cap_hit[0] |=> cap_ff[0] == $past(tcnt_ff);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed count");
    property p_irq;
        flag_set[`I_TOF] && ie_ff[`I_TOF] && ce |=> irq_req[`I_TOF];
    endproperty
    a_irq: assert property (p_irq) else $error("overflow request absent");
    property p_pa_event;
        pa_inc && !(wr && paddr == `A_PACNT) |=> pacnt_ff == 8'($past(pacnt_ff) + 8'h1);
    endproperty
    a_pa_event: assert property (p_pa_event) else $error("accumulator missed");
    property p_wd_fire;
        s_wd_expire ##1 ce [*8] |-> s_pin_low;
    endproperty
    a_wd_fire: assert property (p_wd_fire) else $error("reset pin not held");
endmodule
`default_nettype wire

/* File: timer_consts.svh */
// Register offsets, field positions and fixed counts of the timer system.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define A_CTRL 8'h00
`define A_COUNT 8'h04
`define A_EDGE 8'h08
`define A_IE 8'h0c
`define A_FLAGS 8'h10
`define A_PORT 8'h14
`define A_DDR 8'h18
`define A_OC1 8'h1c
`define A_WDOG 8'h20
`define A_PACNT 8'h24
`define A_STAT 8'h28
`define A_CAP3 8'h4c
`define CAP_PG 4'h4
`define CMP_PG 4'h5
// ==========================================================
// Control and first compare register fields
`define C_W 13
`define C_PSC 1:0
`define C_RTI 3:2
`define C_PA_EN 4
`define C_PA_GATE 5
`define C_PA_POL 6
`define C_IC4 7
`define C_WD_EN 8
`define C_OCEN 12:9
`define O1_W 13
`define O1_MASK 4:0
`define O1_DATA 12:8
// ==========================================================
// Flag and interrupt request bit positions
`define NIRQ 12
`define I_IC4 3
`define I_OC1 4
`define I_TOF 8
`define I_RTI 9
`define I_PAOVF 10
`define I_PAEDG 11
// ==========================================================
// Divider chain taps, watchdog figures and edge codes
`define DIV_W 16
`define PS_SH1 2
`define PS_SH2 3
`define PS_SH3 4
`define PA_SH 6
`define RTI_SH 13
`define WD_SH 15
`define WD_KEY 8'h5a
`define WD_LIMIT 3'h7
`define WD_HOLD 8'h0f
`define EDG_RISE 2'h1
`define EDG_FALL 2'h2
`define EDG_ANY 2'h3
`endif

/* File: timer_pkg.sv */
// Types shared by the timer system files.
package timer_pkg;
    typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_HOLD} wd_state_t;
    typedef logic [15:0] count_t;
endpackage
